/* File: pkg/ubm_pkg.sv */
package ubm_pkg;

    // ----------------------------------------------------------------
    // register map: byte address is four times the register index
    // ----------------------------------------------------------------
    localparam int         ADDR_W     = 12;
    localparam logic [7:0] CTRL_IDX   = 8'h98;
    localparam logic [7:0] DATA_IDX   = 8'h99;
    localparam logic [7:0] CFG_IDX    = 8'h9a;

    // ----------------------------------------------------------------
    // serial_port_control fields
    // ----------------------------------------------------------------
    localparam int         MODE_BIT   = 7;
    localparam int         FIXED_BIT  = 6;
    localparam int         FILT_BIT   = 5;
    localparam int         REN_BIT    = 4;
    localparam int         TX9_BIT    = 3;
    localparam int         RX9_BIT    = 2;
    localparam int         TI_BIT     = 1;
    localparam int         RI_BIT     = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // configuration register fields
    // ----------------------------------------------------------------
    localparam int         CFG_IRQEN_BIT  = 8;
    localparam int         CFG_TXBUSY_BIT = 9;
    localparam int         CFG_RXBUSY_BIT = 10;
    localparam logic [7:0] RELOAD_RESET   = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam logic [7:0] TIMER_TOP     = 8'hff;
    localparam logic [3:0] TX_IDX_START  = 4'h0;
    localparam logic [3:0] TX_IDX_LAST8  = 4'h8;
    localparam logic [3:0] TX_IDX_STOP   = 4'ha;
    localparam logic [3:0] RX_IDX_DATA   = 4'h7;
    localparam logic [3:0] RX_IDX_LAST8  = 4'h8;
    localparam logic [3:0] RX_IDX_LAST9  = 4'h9;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SEND = 2'b10
    } ubm_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10
    } ubm_rx_state_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CTRL = 2'b01,
        SEL_DATA = 2'b10,
        SEL_CFG  = 2'b11
    } ubm_sel_t;

endpackage

/* File: pkg/ubm_baud_if.sv */
`timescale 1ns/1ps
interface ubm_baud_if;
    logic [7:0] reload;
    logic       rxRestart;
    logic       txBitTick;
    logic       rxHalfTick;
    modport gen  (input reload, input rxRestart, output txBitTick, output rxHalfTick);
    modport core (output reload, output rxRestart, input txBitTick, input rxHalfTick);
endinterface

/* File: hdl/ubm_baud_gen.sv */
`timescale 1ns/1ps
module ubm_baud_gen (
    // clock and reset
    input logic     sys_clk,
    input logic     reset_n,
    // bit timing
    ubm_baud_if.gen baud
);
    import ubm_pkg::*;

    function automatic logic [7:0] nextCount(input logic [7:0] cnt, input logic [7:0] reload);
        return (cnt == TIMER_TOP) ? reload : cnt + 8'h01;
    endfunction

    logic [7:0] txCnt_q;
    logic [7:0] rxCnt_q;
    logic       txHalf_q;
    logic       txTick_q;
    logic       rxTick_q;

    // ----------------------------------------------------------------
    // transmit timer: overflow every 256 - reload cycles, halved
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txCnt_q  <= 8'h00;
            txHalf_q <= 1'b0;
            txTick_q <= 1'b0;
        end else begin
            txCnt_q  <= nextCount(txCnt_q, baud.reload);
            txTick_q <= (txCnt_q == TIMER_TOP) && txHalf_q;
            if (txCnt_q == TIMER_TOP) begin
                txHalf_q <= ~txHalf_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // receive timer: same reload, restarted on a start edge
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxCnt_q  <= 8'h00;
            rxTick_q <= 1'b0;
        end else if (baud.rxRestart) begin
            rxCnt_q  <= baud.reload;
            rxTick_q <= 1'b0;
        end else begin
            rxCnt_q  <= nextCount(rxCnt_q, baud.reload);
            rxTick_q <= (rxCnt_q == TIMER_TOP);
        end
    end

    assign baud.txBitTick  = txTick_q;
    assign baud.rxHalfTick = rxTick_q;

    a_rx_reload_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
        baud.rxRestart |=> (rxCnt_q == $past(baud.reload)))
        else $error("rx timer not reloaded on start edge");

    a_tx_tick_gap: assert property (@(posedge sys_clk) disable iff (!reset_n)
        baud.txBitTick |=> !baud.txBitTick)
        else $error("tx bit ticks closer than two overflows");

endmodule // ubm_baud_gen

/* File: hdl/ubm_uart.sv */
`timescale 1ns/1ps
module ubm_uart (
    // clock and reset
    input  logic                       sys_clk,
    input  logic                       reset_n,
    // apb slave
    input  logic [ubm_pkg::ADDR_W-1:0] paddr,
    input  logic                       psel,
    input  logic                       penable,
    input  logic                       pwrite,
    input  logic [31:0]                pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // serial line
    input  logic                       serialIn,
    output logic                       serialOut,
    // interrupt
    output logic                       irq
);
    import ubm_pkg::*;

    function automatic ubm_sel_t regSel(input logic [ADDR_W-1:0] addr);
        if (addr[1:0] != 2'h0) begin
            return SEL_NONE;
        end
        unique case (addr[ADDR_W-1:2])
            (ADDR_W-2)'(CTRL_IDX): return SEL_CTRL;
            (ADDR_W-2)'(DATA_IDX): return SEL_DATA;
            (ADDR_W-2)'(CFG_IDX):  return SEL_CFG;
            default:  return SEL_NONE;
        endcase
    endfunction

    ubm_baud_if baud ();

    ubm_baud_gen u_baud (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .baud    (baud)
    );

    // control and configuration state
    logic          mode_q;
    logic          filt_q;
    logic          ren_q;
    logic          tx9_q;
    logic          rx9_q;
    logic          ti_q;
    logic          ri_q;
    logic          irqEn_q;
    logic [7:0]    reload_q;
    logic [7:0]    rxBuf_q;
    // bus outputs
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;
    logic          irq_q;
    // transmitter
    ubm_tx_state_t txState_q;
    logic [3:0]    txIdx_q;
    logic [3:0]    txNext;
    logic [7:0]    txShift_q;
    logic          txNinth_q;
    logic          txMode9_q;
    logic          serialOut_q;
    logic          tiSet;
    // receiver
    ubm_rx_state_t rxState_q;
    logic [3:0]    rxIdx_q;
    logic          rxPhase_q;
    logic [7:0]    rxShift_q;
    logic          rxNinth_q;
    logic          rxPrev_q;
    logic          rxSample;
    logic          rxLast;
    logic          ninthVal;
    logic          rxAccept;
    // bus decode
    logic          busWr;
    logic          ctrlWr;
    logic          dataWr;
    logic          cfgWr;

    // ----------------------------------------------------------------
    // apb slave: zero wait, outputs registered in the setup cycle
    // ----------------------------------------------------------------
    assign busWr  = psel && penable && pready_q && pwrite;
    assign ctrlWr = busWr && (regSel(paddr) == SEL_CTRL);
    assign dataWr = busWr && (regSel(paddr) == SEL_DATA);
    assign cfgWr  = busWr && (regSel(paddr) == SEL_CFG);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && (regSel(paddr) == SEL_NONE);
            if (psel && !penable) begin
                unique case (regSel(paddr))
                    SEL_CTRL: prdata_q <= {24'h00_0000, mode_q, 1'b1, filt_q, ren_q,
                                           tx9_q, rx9_q, ti_q, ri_q};
                    SEL_DATA: prdata_q <= {24'h00_0000, rxBuf_q};
                    SEL_CFG:  prdata_q <= {21'h00_0000, rxState_q != RX_IDLE,
                                           txState_q != TX_IDLE, irqEn_q, reload_q};
                    SEL_NONE: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // control register; hardware set wins over a software clear
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= CTRL_RESET[MODE_BIT];
            filt_q <= CTRL_RESET[FILT_BIT];
            ren_q  <= CTRL_RESET[REN_BIT];
            tx9_q  <= CTRL_RESET[TX9_BIT];
            rx9_q  <= CTRL_RESET[RX9_BIT];
            ti_q   <= CTRL_RESET[TI_BIT];
            ri_q   <= CTRL_RESET[RI_BIT];
        end else begin
            if (ctrlWr) begin
                mode_q <= pwdata[MODE_BIT];
                filt_q <= pwdata[FILT_BIT];
                ren_q  <= pwdata[REN_BIT];
                tx9_q  <= pwdata[TX9_BIT];
            end
            ti_q  <= tiSet || (ctrlWr ? pwdata[TI_BIT] : ti_q);
            ri_q  <= rxAccept || (ctrlWr ? pwdata[RI_BIT] : ri_q);
            rx9_q <= rxAccept ? ninthVal : (ctrlWr ? pwdata[RX9_BIT] : rx9_q);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqEn_q  <= 1'b0;
            reload_q <= RELOAD_RESET;
        end else if (cfgWr) begin
            irqEn_q  <= pwdata[CFG_IRQEN_BIT];
            reload_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irqEn_q && (ti_q || ri_q);
        end
    end

    assign baud.reload = reload_q;

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    // 8-bit frames jump from the last data bit straight to stop
    assign txNext = (txIdx_q == TX_IDX_LAST8 && !txMode9_q) ? TX_IDX_STOP : txIdx_q + 4'h1;
    assign tiSet  = (txState_q == TX_SEND) && baud.txBitTick && (txIdx_q != TX_IDX_STOP)
                    && (txNext == TX_IDX_STOP);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txState_q   <= TX_IDLE;
            txIdx_q     <= TX_IDX_START;
            txShift_q   <= 8'h00;
            txNinth_q   <= 1'b0;
            txMode9_q   <= 1'b0;
            serialOut_q <= 1'b1;
        end else begin
            unique case (txState_q)
                TX_IDLE: begin
                    // a write while busy is dropped, not queued
                    if (dataWr) begin
                        txShift_q <= pwdata[7:0];
                        txNinth_q <= tx9_q;
                        txMode9_q <= mode_q;
                        txState_q <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (baud.txBitTick) begin
                        serialOut_q <= 1'b0;
                        txIdx_q     <= TX_IDX_START;
                        txState_q   <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (baud.txBitTick) begin
                        if (txIdx_q == TX_IDX_STOP) begin
                            txState_q <= TX_IDLE;
                        end else begin
                            txIdx_q <= txNext;
                            if (txNext == TX_IDX_STOP) begin
                                serialOut_q <= 1'b1;
                            end else if (txNext > TX_IDX_LAST8) begin
                                serialOut_q <= txNinth_q;
                            end else begin
                                serialOut_q <= txShift_q[3'(txNext - 4'h1)];
                            end
                        end
                    end
                end
                default: txState_q <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receiver: half-bit ticks, samples on every second one
    // ----------------------------------------------------------------
    assign baud.rxRestart = (rxState_q == RX_IDLE) && ren_q && rxPrev_q && !serialIn;
    assign rxSample = (rxState_q == RX_BITS) && ren_q && baud.rxHalfTick && !rxPhase_q;
    assign rxLast   = rxIdx_q == (mode_q ? RX_IDX_LAST9 : RX_IDX_LAST8);
    // in 8-bit mode the stop bit stands in the ninth position
    assign ninthVal = mode_q ? rxNinth_q : serialIn;
    // filter passes addresses only when the master marks them
    assign rxAccept = rxSample && rxLast && !ri_q && (!filt_q || ninthVal);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxPrev_q <= 1'b1;
        end else begin
            rxPrev_q <= serialIn;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxState_q <= RX_IDLE;
            rxIdx_q   <= 4'h0;
            rxPhase_q <= 1'b0;
            rxShift_q <= 8'h00;
            rxNinth_q <= 1'b0;
        end else begin
            unique case (rxState_q)
                RX_IDLE: begin
                    if (baud.rxRestart) begin
                        rxState_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (!ren_q) begin
                        rxState_q <= RX_IDLE;
                    end else if (baud.rxHalfTick) begin
                        // a glitch shorter than half a bit is not a start
                        rxState_q <= serialIn ? RX_IDLE : RX_BITS;
                        rxIdx_q   <= 4'h0;
                        rxPhase_q <= 1'b1;
                    end
                end
                RX_BITS: begin
                    if (!ren_q) begin
                        rxState_q <= RX_IDLE;
                    end else if (baud.rxHalfTick) begin
                        rxPhase_q <= ~rxPhase_q;
                    end
                    if (rxSample) begin
                        rxIdx_q <= rxIdx_q + 4'h1;
                        if (rxIdx_q <= RX_IDX_DATA) begin
                            rxShift_q <= {serialIn, rxShift_q[7:1]};
                        end else if (!rxLast) begin
                            rxNinth_q <= serialIn;
                        end
                        if (rxLast) begin
                            rxState_q <= RX_IDLE;
                        end
                    end
                end
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxBuf_q <= 8'h00;
        end else if (rxAccept) begin
            rxBuf_q <= rxShift_q;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign serialOut = serialOut_q;
    assign irq       = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_tx_idle_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (txState_q == TX_IDLE) |-> serialOut_q)
        else $error("line not high while transmitter idle");

    a_ti_at_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ($rose(ti_q) && !$past(ctrlWr) && txState_q == TX_SEND) |-> (serialOut_q && txIdx_q == TX_IDX_STOP))
        else $error("tx done not raised at stop bit start");

    a_flags_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !ctrlWr |=> ((ti_q || !$past(ti_q)) && (ri_q || !$past(ri_q))))
        else $error("done flag cleared without software write");

    a_bit6_reads_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (psel && !penable && !pwrite && regSel(paddr) == SEL_CTRL) |=> prdata_q[FIXED_BIT])
        else $error("control bit 6 did not read one");

    a_rx_disabled: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!ren_q && !ctrlWr) |=> (rxState_q == RX_IDLE))
        else $error("receiver active while disabled");

    a_overrun_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ri_q |=> $stable(rxBuf_q))
        else $error("receive buffer overwritten during overrun");

    a_write_starts_tx: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (txState_q == TX_IDLE && dataWr) |-> ##[1:530] !serialOut_q)
        else $error("data write did not start a frame");

    a_irq_shared: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (irqEn_q && (ti_q || ri_q)) |=> irq_q)
        else $error("interrupt missing for set flag");

endmodule // ubm_uart

/* File: sim/ubm_remote_uart.sv */
`timescale 1ns/1ps
module ubm_remote_uart #(
    parameter int BIT_CYC = 16
) (
    // clock
    input  logic sys_clk,
    // serial lines
    input  logic lineFromDut,
    output logic lineToDut
);

    initial lineToDut = 1'b1;

    // ----------------------------------------------------------------
    // far-end transmitter, whole bit times, lsb first
    // ----------------------------------------------------------------
    task automatic send_frame(input logic [7:0] data, input logic nine, input logic ninth, input logic stopBit);
        logic [10:0] bits;
        int          n;
        bits = {stopBit, ninth, data, 1'b0};
        n = nine ? 11 : 10;
        if (!nine) begin
            bits[9] = stopBit;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            lineToDut <= bits[i];
            repeat (BIT_CYC - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        lineToDut <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // far-end receiver, samples mid-bit
    // ----------------------------------------------------------------
    task automatic take_frame(input int n, output logic [10:0] bits);
        bits = '0;
        // no local limit: the bench's cycle ceiling ends a hang
        while (lineFromDut !== 1'b0) begin
            @(posedge sys_clk);
        end
        repeat (BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            bits[i] = lineFromDut;
            repeat (BIT_CYC) @(posedge sys_clk);
        end
    endtask

endmodule // ubm_remote_uart

/* File: sim/ubm_uart_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, (exp), (got)); end end
module ubm_uart_tb_top;
    import ubm_pkg::*;

    localparam int          BIT_CYC = 16;
    localparam logic [11:0] A_CTRL  = {2'b00, CTRL_IDX, 2'b00};
    localparam logic [11:0] A_DATA  = {2'b00, DATA_IDX, 2'b00};
    localparam logic [11:0] A_CFG   = {2'b00, CFG_IDX, 2'b00};

    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] paddr   = '0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        serialIn;
    logic        serialOut;
    logic        irq;
    int          fails   = 0;
    int          checks  = 0;
    int          cyc     = 0;

    always #12.5 sys_clk = ~sys_clk;

    ubm_uart i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialIn(serialIn), .serialOut(serialOut), .irq(irq));
    ubm_remote_uart #(.BIT_CYC(BIT_CYC)) i_remote (.sys_clk(sys_clk), .lineFromDut(serialOut),
        .lineToDut(serialIn));

    // ----------------------------------------------------------------
    // apb master
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for the answer; only the bench ceiling ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, '0, r, e);
        `CHK(nm, exp, r)
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd_chk("ctrl reset", A_CTRL, 32'h0000_0040);
        wr(A_CTRL, 32'h0000_0000);
        rd_chk("ctrl bit6", A_CTRL, 32'h0000_0040);
        apb(1'b0, 12'hffc, '0, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0000_0000, r)
        apb(1'b0, A_CTRL | 12'h002, '0, r, e);
        `CHK("misaligned err", 1'b1, e)
        wr(A_CFG, 32'h0000_01f8);
        rd_chk("cfg", A_CFG, 32'h0000_01f8);
    endtask

    task automatic t_tx(input logic mode, input logic tx9, input logic [7:0] d);
        logic [10:0] bits;
        logic [7:0]  c;
        c = {mode, 3'b000, tx9, 3'b000};
        wr(A_CTRL, {24'h0, c});
        wr(A_DATA, {24'h0, d});
        rd_chk("tx busy", A_CFG, 32'h0000_03f8);
        i_remote.take_frame(mode ? 11 : 10, bits);
        `CHK("tx frame", mode ? {1'b1, tx9, d, 1'b0} : {2'b01, d, 1'b0}, bits)
        rd_chk("tx done", A_CTRL, {24'h0, c | 8'h42});
        `CHK("irq set", 1'b1, irq)
        wr(A_CTRL, 32'h0);
        repeat (2) @(posedge sys_clk);
        `CHK("irq clear", 1'b0, irq)
    endtask

    task automatic t_rx(input logic [7:0] c, input logic [7:0] d, input logic nine, input logic ninth,
                        input logic stopBit, input logic [7:0] expC, input logic [7:0] expD);
        wr(A_CTRL, {24'h0, c});
        i_remote.send_frame(d, nine, ninth, stopBit);
        rd_chk("rx ctrl", A_CTRL, {24'h0, expC});
        rd_chk("rx data", A_DATA, {24'h0, expD});
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ceiling well above the few thousand cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_tx(1'b0, 1'b1, 8'ha5);
        t_tx(1'b1, 1'b1, 8'h3c);
        t_tx(1'b1, 1'b0, 8'hc3);
        t_rx(8'h10, 8'h5a, 1'b0, 1'b0, 1'b1, 8'h55, 8'h5a);
        t_rx(8'h11, 8'h11, 1'b0, 1'b0, 1'b1, 8'h51, 8'h5a);
        t_rx(8'h00, 8'h22, 1'b0, 1'b0, 1'b1, 8'h40, 8'h5a);
        t_rx(8'h30, 8'h33, 1'b0, 1'b0, 1'b0, 8'h70, 8'h5a);
        t_rx(8'h10, 8'h44, 1'b0, 1'b0, 1'b0, 8'h51, 8'h44);
        t_rx(8'hb0, 8'h66, 1'b1, 1'b0, 1'b1, 8'hf0, 8'h44);
        t_rx(8'hb0, 8'h77, 1'b1, 1'b1, 1'b0, 8'hf5, 8'h77);
        // rx done still set: masking the interrupt must drop the request
        wr(A_CFG, 32'h0000_00f8);
        repeat (2) @(posedge sys_clk);
        `CHK("irq masked", 1'b0, irq)
        give_verdict();
    end

endmodule // ubm_uart_tb_top
